/* File: ptsc_params.svh */
// Purpose: constants of the pixel tone and sharpening control block
// Assumes: 10-bit pixels, 12-bit APB byte address
// Notes:   fixed point: gain Q1.7 steps, ratio and gamma Q2.6, amount Q5.4, threshold Q0.16
`ifndef PTSC_PARAMS_SVH
`define PTSC_PARAMS_SVH
// ****************
// register offsets
// ****************
`define PTSC_OFS_CTRL    12'h000
`define PTSC_OFS_GAIN    12'h004
`define PTSC_OFS_OFFSET  12'h008
`define PTSC_OFS_OFFPCT  12'h00C
`define PTSC_OFS_RATIO   12'h010
`define PTSC_OFS_GAMMA   12'h014
`define PTSC_OFS_AMOUNT  12'h018
`define PTSC_OFS_THRESH  12'h01C
`define PTSC_OFS_STATUS  12'h020
// *********************
// control field layout
// *********************
`define PTSC_CTRL_ENH      0
`define PTSC_CTRL_AUTOTHR  1
`define PTSC_CTRL_TONE     2
`define PTSC_CTRL_DARK     3
`define PTSC_CTRL_AMP_LO   4
`define PTSC_CTRL_WB_LO    6
`define PTSC_CTRL_RSEL     8
`define PTSC_CTRL_ASEL_LO  9
`define PTSC_CTRL_OSEL_LO  11
// ****************************
// reset values and limits
// ****************************
`define PTSC_RST_RATIO     8'h40
`define PTSC_RST_GAMMA     8'h40
`define PTSC_RST_AMOUNT    10'h020
`define PTSC_AMOUNT_MAX    10'sh080
`define PTSC_AMOUNT_MIN    -10'sh010
`define PTSC_THR_MAX       16'h4000
`define PTSC_GAIN_MAX      6'h24
`define PTSC_PCT_MAX       7'h64
`define PTSC_PIX_MAX       10'h3FF
`define PTSC_AG_LOW        10'h300
`define PTSC_AG_HIGH       10'h3FC
`define PTSC_UNITY         8'h40
`endif

/* File: ptsc_pixel_tone_sharpen_ctrl.sv */
// Purpose: pixel offset, gain, balance, tone curve and edge enhancement with APB settings
// Assumes: one clock; frames separated by at least 4 idle cycles
// Notes:   settings are sampled at frame start; pipeline latency 5 cycles
`timescale 1ns/1ps
`include "ptsc_params.svh"
module ptsc_pixel_tone_sharpen_ctrl #(
  parameter int unsigned WB_ONCE_FRAMES = 4
) (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        pix_in_valid,
  input  wire logic        pix_in_sof,
  input  wire logic        pix_in_sol,
  input  wire logic [1:0]  pix_in_colour,
  input  wire logic [9:0]  pix_in_data,
  input  wire logic        rolling_shutter_pin,
  output logic             pix_out_valid,
  output logic             pix_out_sof,
  output logic [9:0]       pix_out_data
);
  // ****************
  // helper functions
  // ****************
  function automatic logic [13:0] ptsc_gain_mult(input logic [5:0] db);
    logic [7:0] frac;
    logic [5:0] oct;
    oct = db / 6'h06;
    unique case (db % 6'h06)
      6'h00:   frac = 8'h80;
      6'h01:   frac = 8'h90;
      6'h02:   frac = 8'hA1;
      6'h03:   frac = 8'hB5;
      6'h04:   frac = 8'hCB;
      default: frac = 8'hE4;
    endcase
    return 14'({6'h00, frac} << oct);
  endfunction

  // log2 and exp2 by leading one and linear mantissa
  function automatic logic [9:0] ptsc_gamma(input logic [9:0] x, input logic [7:0] g);
    logic [3:0]         m;
    logic [9:0]         norm;
    logic signed [23:0] l;
    logic signed [23:0] y;
    logic signed [23:0] yi;
    logic [9:0]         mant;
    m = 4'h0;
    for (int i = 0; i < 10; i++) begin
      if (x[i]) m = 4'(i);
    end
    norm = x << (4'h9 - m);
    l = (($signed({20'h0_0000, m}) - 24'sh00_000A) <<< 9) + $signed({15'h0000, norm[8:0]});
    y = (l * $signed({16'h0000, g})) >>> 6;
    yi = y >>> 9;
    mant = {1'b1, y[8:0]};
    if (x == 10'h000) return 10'h000;
    if (y >= 0) return `PTSC_PIX_MAX;
    if (-yi > 24'sh00_000A) return 10'h000;
    return mant >> 4'(-yi - 24'sh00_0001);
  endfunction

  // ************
  // pin capture
  // ************
  logic [1:0] roll_sync_reg;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) roll_sync_reg <= 2'h0;
    else roll_sync_reg <= {roll_sync_reg[0], rolling_shutter_pin};
  end
  wire rolling = roll_sync_reg[1];

  // ****************
  // register decode
  // ****************
  logic        pready_reg, pslverr_reg;
  logic [31:0] prdata_reg;
  logic        enh_on_reg, auto_thr_reg, tone_on_reg, dark_on_reg, ratio_sel_reg;
  logic [1:0]  amp_mode_reg, wb_mode_reg, amp_sel_reg, off_sel_reg;
  logic [5:0]  gain_reg;
  logic [9:0]  offset_reg, dark_reg, noise_pix;
  logic [7:0]  ratio_r_reg, ratio_b_reg, gamma_reg;
  logic signed [9:0] amount_reg;
  logic [15:0] thr_reg;
  logic [3:0]  wb_cnt_reg;
  logic [13:0] noise_acc_reg;

  wire sel_ctrl   = paddr == `PTSC_OFS_CTRL;
  wire sel_gain   = paddr == `PTSC_OFS_GAIN;
  wire sel_offset = paddr == `PTSC_OFS_OFFSET;
  wire sel_offpct = paddr == `PTSC_OFS_OFFPCT;
  wire sel_ratio  = paddr == `PTSC_OFS_RATIO;
  wire sel_gamma  = paddr == `PTSC_OFS_GAMMA;
  wire sel_amount = paddr == `PTSC_OFS_AMOUNT;
  wire sel_thresh = paddr == `PTSC_OFS_THRESH;
  wire sel_status = paddr == `PTSC_OFS_STATUS;
  wire mapped     = |{sel_ctrl, sel_gain, sel_offset, sel_offpct, sel_ratio, sel_gamma,
                      sel_amount, sel_thresh, sel_status};
  wire bad_acc    = ~mapped | (pwrite & sel_status);
  wire apb_first  = psel & penable & ~pready_reg;
  wire apb_wr     = psel & penable & pready_reg & pwrite & ~pslverr_reg;
  wire osel_all   = off_sel_reg == ptsc_pkg::PTSC_OSEL_ALL;
  wire signed [9:0] wr_amt = pwdata[9:0];
  wire signed [9:0] amt_clamped = (wr_amt > `PTSC_AMOUNT_MAX) ? `PTSC_AMOUNT_MAX :
                                  (wr_amt < `PTSC_AMOUNT_MIN) ? `PTSC_AMOUNT_MIN : wr_amt;
  wire [6:0]  pct_in   = (pwdata[6:0] > `PTSC_PCT_MAX) ? `PTSC_PCT_MAX : pwdata[6:0];
  wire [16:0] pct_raw  = ({10'h000, pct_in} * 17'h0_03FF) / 17'h0_0064;
  wire [16:0] pct_rd   = ({7'h00, offset_reg} * 17'h0_0064) / 17'h0_03FF;
  wire [16:0] noise_thr = {noise_pix, 7'h00};
  wire [15:0] thr_eff  = !auto_thr_reg ? thr_reg :
                         (noise_thr > {1'b0, `PTSC_THR_MAX}) ? `PTSC_THR_MAX : noise_thr[15:0];
  wire [10:0] off_total = {1'b0, offset_reg} + {1'b0, dark_reg};
  wire [9:0]  off_rd   = (off_sel_reg == ptsc_pkg::PTSC_OSEL_ANALOG)  ? offset_reg :
                         (off_sel_reg == ptsc_pkg::PTSC_OSEL_DIGITAL) ? dark_reg :
                         (off_total[10] ? `PTSC_PIX_MAX : off_total[9:0]);
  wire [12:0] ctrl_rd  = {off_sel_reg, amp_sel_reg, ratio_sel_reg, wb_mode_reg, amp_mode_reg,
                          dark_on_reg, tone_on_reg, auto_thr_reg, enh_on_reg};
  wire [31:0] rd_mux   = sel_ctrl   ? {19'h0_0000, ctrl_rd} :
                         sel_gain   ? {26'h000_0000, gain_reg} :
                         sel_offset ? {22'h00_0000, off_rd} :
                         sel_offpct ? {15'h0000, pct_rd} :
                         sel_ratio  ? {24'h00_0000, ratio_sel_reg ? ratio_b_reg : ratio_r_reg} :
                         sel_gamma  ? {24'h00_0000, gamma_reg} :
                         sel_amount ? {{22{amount_reg[9]}}, amount_reg} :
                         sel_thresh ? {16'h0000, thr_eff} :
                         sel_status ? {rolling, 5'h00, dark_reg, 6'h00, noise_pix} :
                         32'h0000_0000;

  // one wait state, read data taken with pready
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= apb_first;
      pslverr_reg <= apb_first & bad_acc;
      if (apb_first & ~pwrite) prdata_reg <= bad_acc ? 32'h0000_0000 : rd_mux;
    end
  end
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign prdata  = prdata_reg;

  // *******************
  // frame statistics
  // *******************
  logic        s0_v, s0_sof, s0_sol, s1_v, s1_sol, s2_v, s2_sol, s3_v, s3_sol, s1_sof, s2_sof, s3_sof;
  logic [1:0]  s0_col, s1_col;
  logic [9:0]  s0_pix, s1_pix, s2_pix, s3_pix, prev1_reg, prev2_reg;
  logic [9:0]  max_reg, min_reg;
  logic [31:0] sum_r_reg, sum_g_reg, sum_b_reg;
  logic [1:0]  s2_col;
  wire frame_start = pix_in_valid & pix_in_sof;
  wire [32:0] r2 = {sum_r_reg, 1'b0};
  wire [32:0] b2 = {sum_b_reg, 1'b0};
  wire [32:0] g1 = {1'b0, sum_g_reg};

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      max_reg   <= 10'h000;
      min_reg   <= `PTSC_PIX_MAX;
      sum_r_reg <= 32'h0000_0000;
      sum_g_reg <= 32'h0000_0000;
      sum_b_reg <= 32'h0000_0000;
      dark_reg  <= 10'h000;
    end else if (frame_start) begin
      max_reg   <= 10'h000;
      min_reg   <= `PTSC_PIX_MAX;
      sum_r_reg <= 32'h0000_0000;
      sum_g_reg <= 32'h0000_0000;
      sum_b_reg <= 32'h0000_0000;
      dark_reg  <= (dark_on_reg & ~rolling) ? min_reg : 10'h000;
    end else begin
      if (pix_in_valid && pix_in_data < min_reg) min_reg <= pix_in_data;
      if (s2_v && s2_pix > max_reg) max_reg <= s2_pix;
      if (s2_v && s2_col == ptsc_pkg::PTSC_COL_RED) sum_r_reg <= sum_r_reg + {22'h00_0000, s2_pix};
      if (s2_v && s2_col == ptsc_pkg::PTSC_COL_GREEN) sum_g_reg <= sum_g_reg + {22'h00_0000, s2_pix};
      if (s2_v && s2_col == ptsc_pkg::PTSC_COL_BLUE) sum_b_reg <= sum_b_reg + {22'h00_0000, s2_pix};
    end
  end

  // ******************************
  // settings and automatic loops
  // ******************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      {enh_on_reg, auto_thr_reg, tone_on_reg, dark_on_reg, ratio_sel_reg} <= 5'h00;
      {amp_mode_reg, wb_mode_reg, amp_sel_reg, off_sel_reg} <= 8'h00;
      gain_reg    <= 6'h00;
      offset_reg  <= 10'h000;
      gamma_reg   <= `PTSC_RST_GAMMA;
      amount_reg  <= `PTSC_RST_AMOUNT;
      thr_reg     <= 16'h0000;
      wb_cnt_reg  <= 4'h0;
    end else if (apb_wr) begin
      if (sel_ctrl) begin
        {off_sel_reg, amp_sel_reg, ratio_sel_reg, wb_mode_reg, amp_mode_reg} <= pwdata[12:4];
        {dark_on_reg, tone_on_reg, auto_thr_reg, enh_on_reg} <= pwdata[3:0];
        wb_cnt_reg <= 4'(WB_ONCE_FRAMES);
      end
      if (sel_gain) gain_reg <= (pwdata[5:0] > `PTSC_GAIN_MAX) ? `PTSC_GAIN_MAX : pwdata[5:0];
      if (sel_offset && osel_all) offset_reg <= pwdata[9:0];
      if (sel_offpct && osel_all) offset_reg <= pct_raw[9:0];
      if (sel_gamma) gamma_reg <= pwdata[7:0];
      if (sel_amount) amount_reg <= amt_clamped;
      if (sel_thresh) thr_reg <= (pwdata[15:0] > `PTSC_THR_MAX) ? `PTSC_THR_MAX : pwdata[15:0];
    end else if (frame_start) begin
      if (amp_mode_reg != ptsc_pkg::PTSC_AUTO_OFF) begin
        if (max_reg < `PTSC_AG_LOW && gain_reg < `PTSC_GAIN_MAX) gain_reg <= gain_reg + 6'h01;
        else if (max_reg >= `PTSC_AG_HIGH && gain_reg != 6'h00) gain_reg <= gain_reg - 6'h01;
        if (amp_mode_reg == ptsc_pkg::PTSC_AUTO_ONCE) amp_mode_reg <= ptsc_pkg::PTSC_AUTO_OFF;
      end
      if (wb_mode_reg == ptsc_pkg::PTSC_AUTO_ONCE) begin
        wb_cnt_reg <= wb_cnt_reg - 4'h1;
        if (wb_cnt_reg <= 4'h1) wb_mode_reg <= ptsc_pkg::PTSC_AUTO_OFF;
      end
    end
  end

  // greens are counted twice per quad, so red and blue sums are doubled
  wire wb_step = frame_start & ~apb_wr & (wb_mode_reg != ptsc_pkg::PTSC_AUTO_OFF);
  wire wr_ratio = apb_wr & sel_ratio;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ratio_r_reg <= `PTSC_RST_RATIO;
      ratio_b_reg <= `PTSC_RST_RATIO;
    end else if (wr_ratio) begin
      if (ratio_sel_reg) ratio_b_reg <= pwdata[7:0];
      else ratio_r_reg <= pwdata[7:0];
    end else if (wb_step) begin
      if (r2 < g1 && ratio_r_reg != 8'hFF) ratio_r_reg <= ratio_r_reg + 8'h01;
      else if (r2 > g1 && ratio_r_reg > 8'h01) ratio_r_reg <= ratio_r_reg - 8'h01;
      if (b2 < g1 && ratio_b_reg != 8'hFF) ratio_b_reg <= ratio_b_reg + 8'h01;
      else if (b2 > g1 && ratio_b_reg > 8'h01) ratio_b_reg <= ratio_b_reg - 8'h01;
    end
  end

  // ******************************
  // frame-consistent shadow copy
  // ******************************
  logic        sh_enh, sh_tone;
  logic [13:0] sh_gmult;
  logic [9:0]  sh_offset, sh_dark, sh_thr;
  logic [7:0]  sh_rr, sh_rb, sh_gamma;
  logic signed [9:0] sh_amount;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      {sh_enh, sh_tone} <= 2'h0;
      sh_gmult  <= 14'h0080;
      {sh_offset, sh_dark, sh_thr} <= 30'h0000_0000;
      {sh_rr, sh_rb, sh_gamma} <= {`PTSC_RST_RATIO, `PTSC_RST_RATIO, `PTSC_RST_GAMMA};
      sh_amount <= `PTSC_RST_AMOUNT;
    end else if (frame_start) begin
      {sh_enh, sh_tone} <= {enh_on_reg, tone_on_reg};
      sh_gmult  <= ptsc_gain_mult(gain_reg);
      sh_offset <= offset_reg;
      sh_dark   <= (dark_on_reg & ~rolling) ? min_reg : 10'h000;
      sh_thr    <= thr_eff[15:6];
      {sh_rr, sh_rb, sh_gamma} <= {ratio_r_reg, ratio_b_reg, gamma_reg};
      sh_amount <= amount_reg;
    end
  end

  // ***************
  // pixel pipeline
  // ***************
  wire [11:0] s1_diff = {2'h0, s0_pix} - {1'b0, {1'b0, sh_offset} + {1'b0, sh_dark}};
  wire [23:0] s2_prod = {14'h0000, s1_pix} * {10'h000, sh_gmult};
  wire [9:0]  s2_gain = (|s2_prod[23:17]) ? `PTSC_PIX_MAX : s2_prod[16:7];
  wire [7:0]  s2_rat  = (s1_col == ptsc_pkg::PTSC_COL_RED)  ? sh_rr :
                        (s1_col == ptsc_pkg::PTSC_COL_BLUE) ? sh_rb : `PTSC_UNITY;
  wire [17:0] s2_bal  = {8'h00, s2_gain} * {10'h000, s2_rat};
  wire [9:0]  s3_next = sh_tone ? ptsc_gamma(s2_pix, sh_gamma) : s2_pix;
  wire [10:0] nb_sum  = {1'b0, prev1_reg} + {1'b0, prev2_reg};
  wire [9:0]  nb      = s3_sol ? s3_pix : nb_sum[10:1];
  wire signed [10:0] d = $signed({1'b0, s3_pix}) - $signed({1'b0, nb});
  wire [10:0] d_abs   = d[10] ? 11'(-d) : d;
  wire signed [20:0] d_amt = 21'(d * sh_amount);
  wire signed [17:0] s4_sum = $signed({8'h00, s3_pix}) + 18'(d_amt >>> 4);
  wire [9:0]  s4_sat  = s4_sum[17] ? 10'h000 : (|s4_sum[16:10]) ? `PTSC_PIX_MAX : s4_sum[9:0];
  wire        enh_hit = sh_enh & (d_abs > {1'b0, sh_thr});
  assign noise_pix = noise_acc_reg[13:4];

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      {s0_v, s1_v, s2_v, s3_v, s0_sof, s1_sof, s2_sof, s3_sof} <= 8'h00;
      {s0_sol, s1_sol, s2_sol, s3_sol} <= 4'h0;
      {s0_col, s1_col, s2_col} <= 6'h00;
      {s0_pix, s1_pix, s2_pix, s3_pix} <= 40'h00_0000_0000;
      {prev1_reg, prev2_reg} <= 20'h0_0000;
      noise_acc_reg <= 14'h0000;
      {pix_out_valid, pix_out_sof} <= 2'h0;
      pix_out_data <= 10'h000;
    end else begin
      {s0_v, s0_sof, s0_sol, s0_col, s0_pix} <=
        {pix_in_valid, pix_in_sof, pix_in_sol, pix_in_colour, pix_in_data};
      {s1_v, s1_sof, s1_sol, s1_col} <= {s0_v, s0_sof, s0_sol, s0_col};
      s1_pix <= s1_diff[11] ? 10'h000 : s1_diff[9:0];
      {s2_v, s2_sof, s2_sol, s2_col} <= {s1_v, s1_sof, s1_sol, s1_col};
      s2_pix <= (|s2_bal[17:16]) ? `PTSC_PIX_MAX : s2_bal[15:6];
      {s3_v, s3_sof, s3_sol} <= {s2_v, s2_sof, s2_sol};
      s3_pix <= s3_next;
      if (s3_v) begin
        prev1_reg <= s3_pix;
        prev2_reg <= s3_sol ? s3_pix : prev1_reg;
      end
      if (s3_v & ~s3_sol) noise_acc_reg <= noise_acc_reg - (noise_acc_reg >> 4) + 14'(d_abs);
      {pix_out_valid, pix_out_sof} <= {s3_v, s3_v & s3_sof};
      pix_out_data <= enh_hit ? s4_sat : s3_pix;
    end
  end

  // ***********
  // assertions
  // ***********
  default clocking ptsc_cb @(posedge clock); endclocking
  default disable iff (!resetn);
  a_pready_wait: assert property (apb_first |=> pready ##1 !pready)
    else $error("pready not a single cycle after access");
  a_enh_bypass: assert property (s3_v && !sh_enh |=> pix_out_data == $past(s3_pix))
    else $error("pixel changed with enhancement off");
  a_amount_zero: assert property (s3_v && sh_amount == 0 |=> pix_out_data == $past(s3_pix))
    else $error("zero amount altered pixel");
  a_amount_range: assert property (amount_reg <= `PTSC_AMOUNT_MAX && amount_reg >= `PTSC_AMOUNT_MIN)
    else $error("amount out of range");
  a_thr_small: assert property (s3_v && d_abs <= {1'b0, sh_thr} |=> pix_out_data == $past(s3_pix))
    else $error("enhanced below threshold");
  a_thr_cap: assert property (thr_eff <= `PTSC_THR_MAX)
    else $error("threshold above quarter range");
  a_gain_once: assert property (frame_start && !apb_wr && amp_mode_reg == ptsc_pkg::PTSC_AUTO_ONCE
    |=> amp_mode_reg == ptsc_pkg::PTSC_AUTO_OFF)
    else $error("once gain mode did not return to off");
  a_offset_ro: assert property (apb_wr && (sel_offset || sel_offpct) && !osel_all
    |=> $stable(offset_reg))
    else $error("read-only black level was written");
  a_tone_bypass: assert property (s2_v && !sh_tone |=> s3_pix == $past(s2_pix))
    else $error("tone curve applied while off");
  a_shadow_hold: assert property (!frame_start |=> $stable(sh_amount) && $stable(sh_thr))
    else $error("settings changed inside a frame");
  a_dark_roll: assert property (frame_start && rolling |=> dark_reg == 10'h000)
    else $error("dark compensation with rolling shutter");
  c_enhanced: cover property (s3_v && enh_hit);
  c_smooth: cover property (s3_v && enh_hit && sh_amount < 0);
  c_auto_gain: cover property (frame_start && amp_mode_reg == ptsc_pkg::PTSC_AUTO_CONT);
  c_bad_addr: cover property (apb_first && bad_acc);
endmodule

/* File: ptsc_pkg.sv */
// Purpose: types of the pixel tone and sharpening control block
// Assumes: used by the design only, the bench does not refer to it
// Notes:   field encodings only, numbers live in ptsc_params.svh
package ptsc_pkg;
  typedef enum logic [1:0] {
    PTSC_AUTO_OFF  = 2'h0,
    PTSC_AUTO_ONCE = 2'h1,
    PTSC_AUTO_CONT = 2'h2
  } ptsc_auto_t;
  typedef enum logic [1:0] {
    PTSC_COL_GREEN = 2'h0,
    PTSC_COL_RED   = 2'h1,
    PTSC_COL_BLUE  = 2'h2
  } ptsc_colour_t;
  typedef enum logic [1:0] {
    PTSC_OSEL_ALL     = 2'h0,
    PTSC_OSEL_ANALOG  = 2'h1,
    PTSC_OSEL_DIGITAL = 2'h2
  } ptsc_osel_t;
endpackage

/* File: ptsc_sensor_model.sv */
// Purpose: sensor readout model feeding frames of green pixels
// Assumes: one pixel per clock inside a frame, no back-pressure
// Notes:   idle data shows the inverse of the last pixel, never a stale copy
`timescale 1ns/1ps
module ptsc_sensor_model (
  input  wire logic       clock,
  output logic            pix_in_valid,
  output logic            pix_in_sof,
  output logic            pix_in_sol,
  output logic [1:0]      pix_in_colour,
  output logic [9:0]      pix_in_data,
  output logic            rolling_shutter_pin
);
  initial begin
    {pix_in_valid, pix_in_sof, pix_in_sol} = 3'h0;
    pix_in_colour = 2'h0;
    pix_in_data = 10'h000;
    rolling_shutter_pin = 1'b0;
  end
  // one line of four pixels, first pixel lowest in the word
  task automatic send_frame(input logic [39:0] pix);
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      pix_in_valid <= 1'b1;
      pix_in_sof <= (i == 0);
      pix_in_sol <= (i == 0);
      pix_in_data <= pix[i*10 +: 10];
    end
    @(posedge clock);
    {pix_in_valid, pix_in_sof, pix_in_sol} <= 3'h0;
    pix_in_data <= ~pix[39:30];
    // idle gap before any next frame start
    repeat (6) @(posedge clock);
  endtask
endmodule

/* File: tb_pixel_tone_sharpen_ctrl.sv */
// Purpose: self-checking bench for the pixel tone and sharpening block
// Assumes: APB answer after one wait state, pixel latency of 5 cycles
// Notes:   green pixels only, so balance ratios leave them unscaled
`timescale 1ns/1ps
`include "ptsc_params.svh"
module tb_pixel_tone_sharpen_ctrl;
  logic        clock, resetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        v, sof, sol, rs, ov, osof;
  logic [1:0]  col;
  logic [9:0]  d, od;
  logic [9:0]  outq[$];
  logic        sofq[$];
  int          error_cnt, num_checks, cyc;
  ptsc_pixel_tone_sharpen_ctrl dut (.clock(clock), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pix_in_valid(v), .pix_in_sof(sof),
    .pix_in_sol(sol), .pix_in_colour(col), .pix_in_data(d), .rolling_shutter_pin(rs),
    .pix_out_valid(ov), .pix_out_sof(osof), .pix_out_data(od));
  ptsc_sensor_model sens (.clock(clock), .pix_in_valid(v), .pix_in_sof(sof),
    .pix_in_sol(sol), .pix_in_colour(col), .pix_in_data(d), .rolling_shutter_pin(rs));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (ov === 1'b1) outq.push_back(od);
    if (ov === 1'b1) sofq.push_back(osof);
    cyc <= cyc + 1;
    // hang guard, far above the few hundred cycles needed
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end
  // ****************
  // shared tasks
  // ****************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, wd, r, e);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(r, exp, "read value");
  endtask
  task automatic frm(input logic [31:0] ctl, amt, thr, input logic [9:0] exp);
    wr(`PTSC_OFS_CTRL, ctl);
    wr(`PTSC_OFS_AMOUNT, amt);
    wr(`PTSC_OFS_THRESH, thr);
    outq.delete();
    sofq.delete();
    sens.send_frame({10'd200, 10'd100, 10'd100, 10'd100});
    repeat (4) @(posedge clock);
    chk(32'(outq.size()), 32'h0000_0004, "pixel count");
    chk({22'h0, outq[0]}, 32'h0000_0064, "flat pixel");
    chk({22'h0, outq[3]}, {22'h0, exp}, "edge pixel");
    chk({28'h0, sofq[0], sofq[1], sofq[2], sofq[3]}, 32'h0000_0008, "frame start flag");
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_regs();
    logic [31:0] r;
    logic        e;
    rdc(`PTSC_OFS_CTRL, 32'h0000_0000);
    rdc(`PTSC_OFS_AMOUNT, 32'h0000_0020);
    apb(1'b0, 12'h024, 32'h0000_0000, r, e);
    chk({31'h0, e}, 32'h0000_0001, "unmapped read");
    wr(`PTSC_OFS_CTRL, 32'h0000_0800);
    wr(`PTSC_OFS_OFFSET, 32'h0000_0009);
    wr(`PTSC_OFS_CTRL, 32'h0000_0000);
    rdc(`PTSC_OFS_OFFSET, 32'h0000_0000);
    wr(`PTSC_OFS_OFFPCT, 32'h0000_0064);
    rdc(`PTSC_OFS_OFFSET, 32'h0000_03FF);
    wr(`PTSC_OFS_OFFSET, 32'h0000_0000);
    wr(`PTSC_OFS_AMOUNT, 32'h0000_0100);
    rdc(`PTSC_OFS_AMOUNT, 32'h0000_0080);
    wr(`PTSC_OFS_AMOUNT, 32'h0000_03E0);
    rdc(`PTSC_OFS_AMOUNT, 32'hFFFF_FFF0);
    wr(`PTSC_OFS_THRESH, 32'h0000_FFFF);
    rdc(`PTSC_OFS_THRESH, 32'h0000_4000);
    wr(`PTSC_OFS_CTRL, 32'h0000_0100);
    wr(`PTSC_OFS_RATIO, 32'h0000_0050);
    wr(`PTSC_OFS_CTRL, 32'h0000_0000);
    rdc(`PTSC_OFS_RATIO, 32'h0000_0040);
  endtask
  task automatic t_auto_gain();
    wr(`PTSC_OFS_CTRL, 32'h0000_0010);
    sens.send_frame({10'd200, 10'd100, 10'd100, 10'd100});
    rdc(`PTSC_OFS_CTRL, 32'h0000_0000);
    rdc(`PTSC_OFS_GAIN, 32'h0000_0001);
  endtask
  // gamma 2.0: linear log/exp approximation lands near p squared over full range
  task automatic t_tone();
    wr(`PTSC_OFS_GAMMA, 32'h0000_0080);
    wr(`PTSC_OFS_CTRL, 32'h0000_0004);
    outq.delete();
    sens.send_frame({10'd200, 10'd100, 10'd100, 10'd100});
    repeat (4) @(posedge clock);
    chk({31'h0, outq[0] inside {[10'd8:10'd10]}}, 32'h0000_0001, "gamma flat");
    chk({31'h0, outq[3] inside {[10'd34:10'd40]}}, 32'h0000_0001, "gamma edge");
  endtask
  // previous frame minimum is 100; rolling shutter must cancel the compensation
  task automatic t_dark();
    wr(`PTSC_OFS_CTRL, 32'h0000_0008);
    repeat (2) begin
      outq.delete();
      sens.send_frame({10'd200, 10'd100, 10'd100, 10'd100});
      repeat (4) @(posedge clock);
      chk({22'h0, outq[3]}, (rs === 1'b1) ? 32'h0000_00C8 : 32'h0000_0064, "dark pixel");
      sens.rolling_shutter_pin <= 1'b1;
      repeat (3) @(posedge clock);
    end
    sens.rolling_shutter_pin <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    {resetn, psel, penable, pwrite} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    {error_cnt, num_checks, cyc} = '0;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    t_regs();
    frm(32'h0000_0000, 32'h0000_0010, 32'h0000_0000, 10'd200);
    frm(32'h0000_0001, 32'h0000_0010, 32'h0000_0000, 10'd300);
    frm(32'h0000_0001, 32'h0000_0010, 32'h0000_4000, 10'd200);
    frm(32'h0000_0001, 32'h0000_0000, 32'h0000_0000, 10'd200);
    frm(32'h0000_0001, 32'h0000_03F0, 32'h0000_0000, 10'd100);
    t_tone();
    t_dark();
    t_auto_gain();
    test_done();
  end
endmodule
